// >>> design/dcl_pkg.sv
package dcl_pkg;
	// control-source selection codes
	localparam logic [2:0] SRC_CONTACT = 3'h0;
	localparam logic [2:0] SRC_KEYPAD = 3'h1;
	localparam logic [2:0] SRC_BUS = 3'h2;
	localparam logic [2:0] SRC_KEYPAD_BUS = 3'h3;
	localparam logic [2:0] SRC_CONTACT_KEYPAD = 3'h4;
	localparam logic [2:0] SRC_THREE_WIRE = 3'h5;
	// multifunction input modes
	localparam logic [2:0] MFI_DIGITAL_LOW = 3'h3;
	localparam logic [2:0] MFI_DIGITAL_HIGH = 3'h4;
	// motor temperature evaluation
	localparam logic [1:0] TEMP_OFF = 2'h0;
	localparam logic [1:0] TEMP_WARN = 2'h1;
	localparam logic [1:0] TEMP_FAULT = 2'h2;
	// signal source codes
	localparam logic [9:0] SIG_OFF = 10'h007;
	localparam logic [9:0] SIG_IN5 = 10'h04B;
	localparam logic [9:0] SIG_MFI2_HW = 10'h214;
	// qualification window
	localparam int QUAL_TIME_MS = 32;
	localparam int CLK_HZ = 250000000;
	localparam int QUAL_CYCLES = QUAL_TIME_MS * (CLK_HZ / 1000);
	localparam int QUAL_W = 24;
	typedef enum logic [1:0] {DCL_IDLE, DCL_QUAL, DCL_RUN} dcl_tw_state_t;
endpackage

// >>> design/dcl_sync.sv
`timescale 1ns/100ps
module dcl_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} dcl_sync_t;
	dcl_sync_t st_ff;
	dcl_sync_t nxt_st;
	always_comb begin
		nxt_st.meta = asyncIn;
		nxt_st.stable = st_ff.meta;
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign syncOut = st_ff.stable;
endmodule // dcl_sync

// >>> design/dcl_window.sv
`timescale 1ns/100ps
module dcl_window #(
	parameter int CYCLES = 8000000,
	parameter int W = 24
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic restart,
	input wire logic hold,
	output logic expired
);
	// counts while hold is high, restart wins
	typedef struct packed {
		logic [W-1:0] cnt;
		logic done;
	} dcl_window_t;
	dcl_window_t st_ff;
	dcl_window_t nxt_st;
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);
	always_comb begin
		nxt_st = st_ff;
		if (restart) begin
			nxt_st.cnt = '0;
			nxt_st.done = 1'b0;
		end else if (hold && !st_ff.done) begin
			nxt_st.cnt = st_ff.cnt + W'(1);
			nxt_st.done = (st_ff.cnt == LAST);
		end
	end
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end
	assign expired = st_ff.done;
endmodule // dcl_window

// >>> design/drive_command_logic.sv
// Operation
// R1 - with three-wire enable on, a forward or reverse rising edge starts the drive
// R2 - in three-wire operation dropping the enable stops the drive
// R3 - run pulses latch while enable is on; latch clears when enable drops
// R4 - once started in three-wire mode further start edges are ignored
// R5 - pulse under 32 ms or both requests within 32 ms stops the drive
// R6 - three-wire behaviour applies only with control source code 5
// R7 - three fixed-frequency selects index one of eight frequencies
// R8 - two fixed-percentage selects index one of four percentages
// R9 - inching request drives toward the inching frequency
// R10 - input fault clear needs contact control or a hardware source
// R11 - panel stop key clears faults only when keypad control allowed
// R12 - command word reset bit from the controller acknowledges the fault
// R13 - thermal contact feeds over-temperature evaluation: off, warning or fault
// R14 - multifunction thermal input must be digital mode 3 or 4
// R15 - speed/torque select chooses controller, changeover supervised while running
// R16 - factory: fault clear from input five, three-wire enable tied off
// R17 - contact inputs count only with source 0, 4 or 5 unless hardware chosen; fixed-frequency and percentage selects are used with any source
// R18 - 32 ms windows from a counter on synchronised inputs
`timescale 1ns/100ps
module drive_command_logic #(
	parameter int QUAL_CYCLES = dcl_pkg::QUAL_CYCLES,
	parameter int FREQ_W = 16,
	parameter int PCT_W = 16
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [2:0] controlSource,
	input wire logic runFwdReq,
	input wire logic runRevReq,
	input wire logic threeWireEnable,
	input wire logic contactHardware,
	input wire logic twoWireRunFwd,
	input wire logic twoWireRunRev,
	input wire logic [2:0] fixFreqSel,
	input wire logic [1:0] fixPctSel,
	input wire logic [8*FREQ_W-1:0] fixFreqTable,
	input wire logic [4*PCT_W-1:0] fixPctTable,
	input wire logic [FREQ_W-1:0] inchFrequency,
	input wire logic inchRunReq,
	input wire logic faultClearInput,
	input wire logic faultClearHardware,
	input wire logic panelStopKey,
	input wire logic cmdWordReset,
	input wire logic motor_overtemp_contact,
	input wire logic overtempHardware,
	input wire logic [1:0] overtempMode,
	input wire logic [2:0] multi_input2_mode,
	input wire logic overtempIsMultiInput,
	input wire logic speedTorqueSel,
	input wire logic driveRunning,
	output logic driveRun,
	output logic driveDirRev,
	output logic startPulse,
	output logic stopPulse,
	output logic [FREQ_W-1:0] fixFreqOut,
	output logic [PCT_W-1:0] fixPctOut,
	output logic inchActive,
	output logic [FREQ_W-1:0] inchTarget,
	output logic faultAck,
	output logic overtempWarning,
	output logic overtempFault,
	output logic overtempCfgError,
	output logic torqueCtrlActive,
	output logic ctrlChangeover
);
	localparam int NSYNC = 13;
	localparam int CW = dcl_pkg::QUAL_W;

	typedef struct packed {
		logic fwdPrev;
		logic revPrev;
		logic enPrev;
		dcl_pkg::dcl_tw_state_t twState;
		logic dirRev;
		logic run;
		logic start;
		logic stop;
		logic [FREQ_W-1:0] freq;
		logic [PCT_W-1:0] pct;
		logic inch;
		logic [FREQ_W-1:0] inchFreq;
		logic ack;
		logic warn;
		logic fault;
		logic cfgErr;
		logic torque;
		logic change;
	} dcl_state_t;

	dcl_state_t st_ff;
	dcl_state_t nxt_st;
	logic [NSYNC-1:0] pinSync;
	logic fwdS, revS, enS, tw2FwdS, tw2RevS, inchS, clrS, keyS, tempS;
	logic [2:0] ffSelS;
	logic [1:0] fpSelS;
	logic fwdRise, revRise, contactOk, threeWire, winRestart, winExpired;

	// pin-side signals pass two flops; panelStopKey is used unsynchronised
	dcl_sync #(
		.W(NSYNC)
	) u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.asyncIn({runFwdReq, runRevReq, threeWireEnable, twoWireRunFwd, twoWireRunRev,
			fixFreqSel, fixPctSel, inchRunReq, faultClearInput, motor_overtemp_contact}),
		.syncOut(pinSync)
	); // R18
	assign {fwdS, revS, enS, tw2FwdS, tw2RevS, ffSelS, fpSelS, inchS, clrS, tempS} = pinSync;
	assign keyS = panelStopKey;

	function automatic logic contact_allowed(input logic [2:0] src);
		contact_allowed = (src == dcl_pkg::SRC_CONTACT) ||
			(src == dcl_pkg::SRC_CONTACT_KEYPAD) || (src == dcl_pkg::SRC_THREE_WIRE);
	endfunction

	function automatic logic keypad_allowed(input logic [2:0] src);
		keypad_allowed = (src == dcl_pkg::SRC_KEYPAD) ||
			(src == dcl_pkg::SRC_KEYPAD_BUS) || (src == dcl_pkg::SRC_CONTACT_KEYPAD);
	endfunction

	// a hardware-suffixed source is evaluated whatever the control-source code
	assign contactOk = contact_allowed(controlSource) || contactHardware; // R17
	assign threeWire = (controlSource == dcl_pkg::SRC_THREE_WIRE); // R6
	assign fwdRise = fwdS && !st_ff.fwdPrev;
	assign revRise = revS && !st_ff.revPrev;
	// window restarts on a start edge in DCL_IDLE and runs while the state is DCL_QUAL
	assign winRestart = (st_ff.twState == dcl_pkg::DCL_IDLE) && (fwdRise || revRise);

	dcl_window #(
		.CYCLES(QUAL_CYCLES),
		.W(CW)
	) u_window (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.restart(winRestart),
		.hold(st_ff.twState == dcl_pkg::DCL_QUAL),
		.expired(winExpired)
	); // R18

	always_comb begin
		nxt_st = st_ff;
		nxt_st.fwdPrev = fwdS;
		nxt_st.revPrev = revS;
		nxt_st.enPrev = enS;
		nxt_st.start = 1'b0;
		nxt_st.stop = 1'b0;
		if (threeWire) begin
			case (st_ff.twState)
				dcl_pkg::DCL_IDLE: begin
					// start latches on the edge; qualification follows
					if (enS && (fwdRise || revRise)) begin // R1 R3
						nxt_st.twState = dcl_pkg::DCL_QUAL;
						nxt_st.dirRev = revRise && !fwdRise;
						nxt_st.run = 1'b1;
						nxt_st.start = 1'b1;
						if (fwdRise && revRise) begin // R5
							nxt_st.twState = dcl_pkg::DCL_IDLE;
							nxt_st.run = 1'b0;
							nxt_st.start = 1'b0;
							nxt_st.stop = 1'b1;
						end
					end
				end
				dcl_pkg::DCL_QUAL: begin
					if (!enS) begin // R2 R3
						nxt_st.twState = dcl_pkg::DCL_IDLE;
						nxt_st.run = 1'b0;
						nxt_st.stop = 1'b1;
					end else if ((st_ff.dirRev ? fwdRise : revRise) ||
						(st_ff.dirRev ? !revS : !fwdS)) begin // R5
						nxt_st.twState = dcl_pkg::DCL_IDLE;
						nxt_st.run = 1'b0;
						nxt_st.stop = 1'b1;
					end else if (winExpired) begin
						nxt_st.twState = dcl_pkg::DCL_RUN;
					end
				end
				dcl_pkg::DCL_RUN: begin
					// further edges ignored until enable drops
					if (!enS) begin // R2 R3 R4
						nxt_st.twState = dcl_pkg::DCL_IDLE;
						nxt_st.run = 1'b0;
						nxt_st.stop = 1'b1;
					end
				end
				default: begin
					nxt_st.twState = dcl_pkg::DCL_IDLE;
					nxt_st.run = 1'b0;
				end
			endcase
		end else begin
			// two-wire contact control outside three-wire mode
			nxt_st.twState = dcl_pkg::DCL_IDLE;
			nxt_st.run = contactOk && (tw2FwdS ^ tw2RevS);
			nxt_st.dirRev = contactOk && tw2RevS && !tw2FwdS;
			nxt_st.start = nxt_st.run && !st_ff.run;
			nxt_st.stop = !nxt_st.run && st_ff.run;
		end
		nxt_st.freq = fixFreqTable[ffSelS*FREQ_W +: FREQ_W]; // R7
		nxt_st.pct = fixPctTable[fpSelS*PCT_W +: PCT_W]; // R8
		nxt_st.inch = inchS && contactOk; // R9
		nxt_st.inchFreq = inchS ? inchFrequency : '0; // R9
		// fault acknowledge sources, registered level held as long as a source is active
		nxt_st.ack = ((clrS && (contactOk || faultClearHardware)) || // R10 R16
			(keyS && keypad_allowed(controlSource)) || // R11
			cmdWordReset); // R12
		// thermal contact: invalid multifunction mode forces no evaluation
		nxt_st.cfgErr = overtempIsMultiInput &&
			(multi_input2_mode != dcl_pkg::MFI_DIGITAL_LOW) &&
			(multi_input2_mode != dcl_pkg::MFI_DIGITAL_HIGH); // R14
		nxt_st.warn = 1'b0;
		nxt_st.fault = 1'b0;
		if (tempS && !nxt_st.cfgErr && (contactOk || overtempHardware)) begin // R13
			nxt_st.warn = (overtempMode == dcl_pkg::TEMP_WARN);
			nxt_st.fault = (overtempMode == dcl_pkg::TEMP_FAULT);
		end
		nxt_st.torque = speedTorqueSel; // R15
		nxt_st.change = (speedTorqueSel != st_ff.torque) && driveRunning; // R15
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign driveRun = st_ff.run;
	assign driveDirRev = st_ff.dirRev;
	assign startPulse = st_ff.start;
	assign stopPulse = st_ff.stop;
	assign fixFreqOut = st_ff.freq;
	assign fixPctOut = st_ff.pct;
	assign inchActive = st_ff.inch;
	assign inchTarget = st_ff.inchFreq;
	assign faultAck = st_ff.ack;
	assign overtempWarning = st_ff.warn;
	assign overtempFault = st_ff.fault;
	assign overtempCfgError = st_ff.cfgErr;
	assign torqueCtrlActive = st_ff.torque;
	assign ctrlChangeover = st_ff.change;
endmodule // drive_command_logic

// >>> verification/dcl_checker.sv
`timescale 1ns/100ps
module dcl_checker #(
	parameter int FREQ_W = 16
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [2:0] controlSource,
	input wire logic runFwdReq,
	input wire logic runRevReq,
	input wire logic threeWireEnable,
	input wire logic [2:0] fixFreqSel,
	input wire logic [8*FREQ_W-1:0] fixFreqTable,
	input wire logic panelStopKey,
	input wire logic cmdWordReset,
	input wire logic driveRun,
	input wire logic startPulse,
	input wire logic stopPulse,
	input wire logic [FREQ_W-1:0] fixFreqOut,
	input wire logic faultAck
);
	logic [2:0] upCnt_ff;
	logic tw;
	// pins cross a two-stage synchroniser, so their effect trails by three edges
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			upCnt_ff <= 3'h0;
		else if (upCnt_ff != 3'h4)
			upCnt_ff <= upCnt_ff + 3'h1;
	end
	assign tw = controlSource == dcl_pkg::SRC_THREE_WIRE;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence fwdEdge;
		tw && threeWireEnable && !runRevReq && !driveRun && $rose(runFwdReq);
	endsequence
	sequence armedHold;
		(tw && threeWireEnable && !runRevReq)[*2];
	endsequence
	AST_FREQ: assert property (upCnt_ff == 3'h4 |->
		fixFreqOut == fixFreqTable[$past(fixFreqSel, 3)*FREQ_W +: FREQ_W])
		else $error("fixed frequency mismatch");
	AST_START: assert property (fwdEdge ##1 armedHold |=> startPulse)
		else $error("no start after run edge");
	AST_NO_RESTART: assert property (tw && $past(tw) && driveRun && $past(driveRun)
		|-> !startPulse) else $error("start while running");
	AST_EN_DROP: assert property (tw && driveRun && $fell(threeWireEnable)
		|-> ##3 (stopPulse && !driveRun)) else $error("enable drop did not stop");
	AST_START_RUN: assert property (startPulse |-> driveRun && !stopPulse)
		else $error("start pulse without run");
	AST_STOP: assert property (stopPulse |-> !driveRun)
		else $error("stop pulse with run");
	AST_KEY: assert property (panelStopKey && controlSource inside {3'h1, 3'h3, 3'h4}
		|=> faultAck) else $error("key clear not acknowledged");
	AST_CMD: assert property (cmdWordReset |=> faultAck)
		else $error("command reset not acknowledged");
endmodule // dcl_checker
bind drive_command_logic dcl_checker #(.FREQ_W(FREQ_W)) u_chk (.sys_clk, .rst_n,
	.controlSource, .runFwdReq, .runRevReq, .threeWireEnable, .fixFreqSel, .fixFreqTable,
	.panelStopKey, .cmdWordReset, .driveRun, .startPulse, .stopPulse, .fixFreqOut, .faultAck);

// >>> verification/dcl_plant.sv
`timescale 1ns/100ps
module dcl_plant (
	input wire logic sys_clk,
	output logic runFwdReq,
	output logic runRevReq
);
	initial begin
		runFwdReq = 1'b0;
		runRevReq = 1'b0;
	end
	// contact held gap+len cycles; gap > 0 closes reverse too, that many cycles later
	task automatic press(input logic rev, input int len, input int gap);
		@(negedge sys_clk);
		if (rev)
			runRevReq = 1'b1;
		else
			runFwdReq = 1'b1;
		repeat (gap) @(negedge sys_clk);
		if (gap > 0)
			runRevReq = 1'b1;
		repeat (len) @(negedge sys_clk);
		runFwdReq = 1'b0;
		runRevReq = 1'b0;
	endtask
endmodule // dcl_plant

// >>> verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic sys_clk, rst_n, en, fwd, rev, inchReq, fcIn, fcHw, key, cmdRst, otC, otHw, otMi, cHw;
	logic stSel, running, run, dirRev, startP, stopP, inchAct, ack, otW, otF, otE, tq, chg;
	logic seenChg;
	logic [2:0] src, fSel, m2Mode;
	logic [1:0] pSel, otMode;
	logic [127:0] fTab;
	logic [63:0] pTab;
	logic [15:0] fOut, pOut, inchTgt;
	int n_fail, tests_run;
	// short window keeps the 32 ms qualification affordable in simulation
	drive_command_logic #(.QUAL_CYCLES(20)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.controlSource(src), .runFwdReq(fwd), .runRevReq(rev), .threeWireEnable(en),
		.contactHardware(cHw), .twoWireRunFwd(1'b0), .twoWireRunRev(1'b0),
		.fixFreqSel(fSel), .fixPctSel(pSel), .fixFreqTable(fTab), .fixPctTable(pTab),
		.inchFrequency(16'h1234), .inchRunReq(inchReq), .faultClearInput(fcIn),
		.faultClearHardware(fcHw), .panelStopKey(key), .cmdWordReset(cmdRst),
		.motor_overtemp_contact(otC), .overtempHardware(otHw), .overtempMode(otMode),
		.multi_input2_mode(m2Mode), .overtempIsMultiInput(otMi), .speedTorqueSel(stSel),
		.driveRunning(running), .driveRun(run), .driveDirRev(dirRev), .startPulse(startP),
		.stopPulse(stopP), .fixFreqOut(fOut), .fixPctOut(pOut), .inchActive(inchAct),
		.inchTarget(inchTgt), .faultAck(ack), .overtempWarning(otW), .overtempFault(otF),
		.overtempCfgError(otE), .torqueCtrlActive(tq), .ctrlChangeover(chg));
	dcl_plant u_plant (.sys_clk(sys_clk), .runFwdReq(fwd), .runRevReq(rev));
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			seenChg <= 1'b0;
		else if (chg)
			seenChg <= 1'b1;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic fa(input logic [2:0] s, input logic hw, fi, k, c, e);
		src = s;
		fcHw = hw;
		{fcIn, key, cmdRst} = {fi, k, c};
		w(5);
		chk(ack, e);
		{fcIn, key, cmdRst} = 3'h0;
		w(5);
	endtask
	task automatic ot(input logic [1:0] m, input logic [2:0] mm, input logic [2:0] e);
		otMode = m;
		m2Mode = mm;
		w(5);
		chk({otW, otF, otE}, e);
	endtask
	task conclude;
		$display("comparisons %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (2000) @(posedge sys_clk);
		n_fail++;
		conclude;
	end
	initial begin
		{rst_n, en, inchReq, fcIn, fcHw, key, cmdRst, stSel, running, cHw} = 10'h0;
		{src, fSel, pSel, otMode} = 10'h0;
		{otC, otHw, otMi} = 3'h7;
		m2Mode = dcl_pkg::MFI_DIGITAL_LOW;
		for (int i = 0; i < 8; i++) fTab[i*16 +: 16] = 16'hA000 + 16'(i);
		for (int i = 0; i < 4; i++) pTab[i*16 +: 16] = 16'hB000 + 16'(i);
		w(3);
		rst_n = 1'b1;
		for (int i = 0; i < 8; i++) begin
			fSel = 3'(i);
			pSel = 2'(i);
			w(4);
			chk(fOut, 16'hA000 + 16'(i));
			chk(pOut, 16'hB000 + 16'(i % 4));
		end
		$display("test fixed selects done");
		src = dcl_pkg::SRC_THREE_WIRE;
		en = 1'b1;
		w(4);
		u_plant.press(1'b0, 30, 0);
		w(5);
		chk({run, dirRev}, 2'h2);
		u_plant.press(1'b1, 30, 0);
		w(5);
		chk({run, dirRev}, 2'h2);
		en = 1'b0;
		w(5);
		chk(run, 1'b0);
		en = 1'b1;
		w(4);
		u_plant.press(1'b0, 5, 0);
		w(30);
		chk(run, 1'b0);
		u_plant.press(1'b0, 30, 3);
		w(5);
		chk(run, 1'b0);
		u_plant.press(1'b1, 30, 0);
		w(5);
		chk({run, dirRev}, 2'h3);
		src = dcl_pkg::SRC_CONTACT;
		w(4);
		u_plant.press(1'b0, 30, 0);
		w(5);
		chk(run, 1'b0);
		$display("test three-wire done");
		en = 1'b0;
		fa(3'h2, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		fa(3'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
		fa(3'h2, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
		fa(3'h1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
		fa(3'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		fa(3'h2, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
		fa(3'h4, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
		fa(3'h3, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
		$display("test fault clear done");
		src = dcl_pkg::SRC_CONTACT;
		inchReq = 1'b1;
		w(5);
		chk({inchAct, inchTgt}, 17'h11234);
		src = dcl_pkg::SRC_BUS;
		w(5);
		chk(inchAct, 1'b0);
		cHw = 1'b1;
		w(5);
		chk(inchAct, 1'b1);
		cHw = 1'b0;
		src = dcl_pkg::SRC_CONTACT;
		ot(dcl_pkg::TEMP_OFF, dcl_pkg::MFI_DIGITAL_LOW, 3'h0);
		ot(dcl_pkg::TEMP_WARN, dcl_pkg::MFI_DIGITAL_LOW, 3'h4);
		ot(dcl_pkg::TEMP_FAULT, dcl_pkg::MFI_DIGITAL_HIGH, 3'h2);
		ot(dcl_pkg::TEMP_FAULT, 3'h0, 3'h1);
		otC = 1'b0;
		ot(dcl_pkg::TEMP_FAULT, dcl_pkg::MFI_DIGITAL_HIGH, 3'h0);
		running = 1'b1;
		stSel = 1'b1;
		w(5);
		chk({tq, seenChg, chg}, 3'h6);
		$display("test inching, temperature, controller done");
		conclude;
	end
endmodule // tb_top
